// ==== logic/nvram_decode_pkg.sv ====
// Constants shared by the byte-wide decode and supply sequencing logic.
// Assumes a single processor clock at 125 MHz.
package nvram_decode_pkg;
  // Top of the byte-wide window; bit 15 clear means the SRAM window.
  localparam logic [15:0] BW_LIMIT      = 16'h7FFF;
  localparam int          BW_AW         = 15;
  localparam int          BW_TOP_BIT    = 15;
  // Power-fail interrupt vector address.
  localparam logic [15:0] PFW_VECTOR    = 16'h002B;
  // Partition granularity: one protect bit per 4K block of the window.
  localparam int          PART_BLOCKS   = 8;
  localparam int          PART_SHIFT    = 12;
  // Supply sequence states, ordered by falling threshold.
  typedef enum logic [1:0] {
    SUP_NORMAL  = 2'b00,
    SUP_WARN    = 2'b01,
    SUP_RESET   = 2'b10,
    SUP_BATTERY = 2'b11
  } supply_state_t;
endpackage : nvram_decode_pkg

// ==== logic/level_sync.sv ====
// Three-stage synchroniser with agreement filter for one async level.
// Assumes the input may change at any time relative to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module level_sync (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Asynchronous level in, filtered level out.
  input  wire logic async_in,
  output var  logic level_q
);
  // Whole state of the synchroniser in one packed struct.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  // Only the second and third stages are compared, never the first.
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  // Registers with a constant reset value.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_q = st_q.lvl;
endmodule // level_sync
`default_nettype wire

// ==== logic/bytewide_decode_power_fail.sv ====
// Byte-wide SRAM decode, write protection and supply-fail sequencing.
// Assumes the core issues one access request per cycle, and that the
// comparator inputs are active high when supply is below each threshold.
// Function
// - 0000h-7FFFh accesses go to primary SRAM select.
// - Unmapped accesses use multiplexed expanded bus.
// - Second data-only 32K bank via bank-2 select.
// - Bank-2 data access never appears on ports.
// - Enabled warning flag vectors interrupt to 2Bh.
// - Warning never halts or alters processing.
// - Reset threshold holds core in reset.
// - Selects and write strobe high during reset.
// - Top address bit keeps level in reset.
// - Below battery level switch supply to battery.
// - Events ordered warning, reset, then battery.
// - Top two address bits driven inverted.
// - No write strobe to program-partition blocks.
`timescale 1ns/10ps
`default_nettype none
module bytewide_decode_power_fail (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Core access request.
  input  wire logic        acc_valid,
  input  wire logic        acc_is_data,
  input  wire logic        acc_write,
  input  wire logic        acc_bank2,
  input  wire logic [15:0] acc_addr,
  input  wire logic [7:0]  acc_wdata,
  output logic [7:0]       acc_rdata_q,
  // Configuration.
  input  wire logic        pfw_enable,
  input  wire logic [7:0]  program_block_mask,
  // Supply comparators, high when supply is below the level.
  input  wire logic        warning_threshold,
  input  wire logic        reset_threshold,
  input  wire logic        battery_level,
  // Byte-wide bus.
  output logic             primary_sram_select_n_q,
  output logic             data_bank2_select_n_q,
  output logic             write_strobe_n_q,
  output logic [14:0]      bytewide_address_q,
  output logic [7:0]       bytewide_data_out_q,
  output logic             bytewide_data_oe_q,
  input  wire logic [7:0]  bytewide_data_in,
  // Expanded bus request and core controls.
  output logic             expanded_req_q,
  output logic             pfw_irq_q,
  output logic [15:0]      pfw_vector_q,
  output logic             core_reset_q,
  output logic             supply_on_battery_q
);
  // Synchronised comparator levels.
  logic warn_s;
  logic rst_s;
  logic batt_s;

  // Every comparator passes four flops before use.
  level_sync u_sync_warn (.clk_sys(clk_sys), .reset_n(reset_n),
    .async_in(warning_threshold), .level_q(warn_s));
  level_sync u_sync_rst (.clk_sys(clk_sys), .reset_n(reset_n),
    .async_in(reset_threshold), .level_q(rst_s));
  level_sync u_sync_batt (.clk_sys(clk_sys), .reset_n(reset_n),
    .async_in(battery_level), .level_q(batt_s));

  // Whole module state in one struct.
  typedef struct packed {
    nvram_decode_pkg::supply_state_t sup;
    logic        ce1_n;
    logic        ce2_n;
    logic        we_n;
    logic [14:0] addr;
    logic [7:0]  dout;
    logic        doe;
    logic [7:0]  rdata;
    logic        exp_req;
    logic        irq;
    logic        warn_prev;
    logic        core_rst;
    logic        on_batt;
  } dec_state_t;

  dec_state_t st_q;
  dec_state_t st_d;

  // Decode helpers.
  logic       in_window;
  logic [2:0] blk;
  logic       prot;
  logic       held;

  // Window hit and partition protect lookup.
  always_comb begin
    in_window = (acc_addr <= nvram_decode_pkg::BW_LIMIT);
    blk  = acc_addr[nvram_decode_pkg::BW_TOP_BIT-1 -: 3];
    prot = program_block_mask[blk] & ~acc_is_data;
    // Program-space writes never exist, but data writes into a
    // program-designated block are also refused.
    prot = program_block_mask[blk];
    held = (st_q.sup == nvram_decode_pkg::SUP_RESET) ||
           (st_q.sup == nvram_decode_pkg::SUP_BATTERY);
  end

  // Next-state logic for supply sequence and bus drive.
  always_comb begin
    st_d = st_q;
    // Sequence follows the deepest threshold crossed.
    if (batt_s) begin
      st_d.sup = nvram_decode_pkg::SUP_BATTERY;
    end else if (rst_s) begin
      st_d.sup = nvram_decode_pkg::SUP_RESET;
    end else if (warn_s) begin
      st_d.sup = nvram_decode_pkg::SUP_WARN;
    end else begin
      st_d.sup = nvram_decode_pkg::SUP_NORMAL;
    end
    st_d.warn_prev = warn_s;
    // Interrupt pulse on warning entry; processing is untouched.
    st_d.irq = warn_s & ~st_q.warn_prev & pfw_enable & ~held;
    st_d.core_rst = rst_s | batt_s;
    st_d.on_batt  = batt_s;
    // Default: bus idle.
    st_d.ce1_n   = 1'b1;
    st_d.ce2_n   = 1'b1;
    st_d.we_n    = 1'b1;
    st_d.doe     = 1'b0;
    st_d.exp_req = 1'b0;
    st_d.rdata   = bytewide_data_in;
    if (held || rst_s || batt_s) begin
      // Strobes inactive; top address bit keeps its level.
      st_d.addr = {st_q.addr[14], 14'h0000};
    end else if (acc_valid) begin
      // Top two bits inverted from the logical address.
      st_d.addr = {~acc_addr[14], ~acc_addr[13], acc_addr[12:0]};
      case ({acc_bank2 & acc_is_data, in_window})
        2'b10, 2'b11: begin
          // Data-only bank; ports stay quiet.
          st_d.ce2_n = 1'b0;
          st_d.we_n  = ~acc_write;
          st_d.doe   = acc_write;
        end
        2'b01: begin
          st_d.ce1_n = 1'b0;
          st_d.we_n  = ~(acc_write & acc_is_data & ~prot);
          st_d.doe   = acc_write & acc_is_data & ~prot;
        end
        default: begin
          st_d.exp_req = 1'b1;
        end
      endcase
      st_d.dout = acc_wdata;
    end
  end

  // State register; outputs inactive from reset, except core reset, which starts asserted.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q       <= '0;
      st_q.ce1_n <= 1'b1;
      st_q.ce2_n <= 1'b1;
      st_q.we_n  <= 1'b1;
      st_q.core_rst <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops, except the constant interrupt vector.
  assign primary_sram_select_n_q = st_q.ce1_n;
  assign data_bank2_select_n_q   = st_q.ce2_n;
  assign write_strobe_n_q        = st_q.we_n;
  assign bytewide_address_q      = st_q.addr;
  assign bytewide_data_out_q     = st_q.dout;
  assign bytewide_data_oe_q      = st_q.doe;
  assign acc_rdata_q             = st_q.rdata;
  assign expanded_req_q          = st_q.exp_req;
  assign pfw_irq_q               = st_q.irq;
  assign pfw_vector_q            = nvram_decode_pkg::PFW_VECTOR;
  assign core_reset_q            = st_q.core_rst;
  assign supply_on_battery_q     = st_q.on_batt;

  // Strobes stay high while supply is at reset level.
  strobes_held_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    core_reset_q |-> (primary_sram_select_n_q && data_bank2_select_n_q
                      && write_strobe_n_q))
    else $error("strobe active during supply reset");
  // Bank-2 access never raises an expanded bus request.
  bank2_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !data_bank2_select_n_q |-> !expanded_req_q)
    else $error("bank-2 access leaked to ports");
  // Window access selects primary SRAM next cycle.
  window_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (acc_valid && !acc_addr[15] && !acc_bank2 && !rst_s && !batt_s
     && !core_reset_q) |=> !primary_sram_select_n_q)
    else $error("window access missed primary select");
  // Outside window goes to expanded bus.
  exp_route_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (acc_valid && acc_addr[15] && !acc_bank2 && !rst_s && !batt_s
     && !core_reset_q) |=> expanded_req_q && primary_sram_select_n_q)
    else $error("unmapped access not on expanded bus");
  // Protected block never sees a write strobe.
  protect_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!primary_sram_select_n_q && !write_strobe_n_q) |->
      !$past(program_block_mask[acc_addr[14:12]]))
    else $error("write strobe to program block");
  // Warning interrupt only when enabled.
  irq_enable_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pfw_irq_q |-> $past(pfw_enable) && $past(warn_s))
    else $error("interrupt without enabled warning");
  // Top address bit holds while held in reset.
  top_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (core_reset_q && $past(core_reset_q)) |->
      $stable(bytewide_address_q[14]))
    else $error("top address bit moved in reset");
  // Battery implies reset.
  order_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    supply_on_battery_q |-> core_reset_q)
    else $error("battery without reset");
  // Inversion of address bit 13.
  invert_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (acc_valid && !rst_s && !batt_s && !core_reset_q) |=>
      bytewide_address_q[13] == !$past(acc_addr[13]))
    else $error("address bit 13 not inverted");
endmodule // bytewide_decode_power_fail
`default_nettype wire

// ==== tb/sram_pair_model.sv ====
// Behavioural pair of byte-wide static RAMs on the two chip selects.
// Assumes active-low selects and strobe, registered by the block.
`timescale 1ns/10ps
`default_nettype none
module sram_pair_model (
  // Clock used to time writes.
  input  wire logic        clk_sys,
  // Shared byte-wide bus.
  input  wire logic        primary_sram_select_n_q,
  input  wire logic        data_bank2_select_n_q,
  input  wire logic        write_strobe_n_q,
  input  wire logic [14:0] bytewide_address_q,
  input  wire logic [7:0]  bytewide_data_out_q,
  output logic [7:0]       bytewide_data_in
);
  logic [7:0]  mem [0:65535]; // Bank 2 lives in the upper half.
  logic [7:0]  last_q = 8'h00; // Last byte seen on the data lines.
  logic        sel;            // Either chip enabled.
  logic [15:0] idx;            // Chip and address as one index.
  // Both chips share strobe, address and data; only the selects differ.
  assign sel = !primary_sram_select_n_q || !data_bank2_select_n_q;
  assign idx = {!data_bank2_select_n_q, bytewide_address_q};
  // An idle bus shows the inverse of the last byte, so stale data never
  // passes for a fresh read.
  assign bytewide_data_in = (sel && write_strobe_n_q) ? mem[idx] : ~last_q;
  // Writes land on the edge that sees strobe and select low together.
  always @(posedge clk_sys) begin
    if (sel && !write_strobe_n_q) begin
      mem[idx] <= bytewide_data_out_q;
    end
    last_q <= bytewide_data_in;
  end
endmodule // sram_pair_model
`default_nettype wire

// ==== tb/test_bytewide_decode_power_fail.sv ====
// Self-checking bench for byte-wide decode and supply sequencing.
// Assumes the RAM pair model sits on the byte-wide bus.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  n_errors++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end end
module test_bytewide_decode_power_fail;
  // One access and the {select1, select2, strobe, expanded} it should give.
  typedef struct packed {
    logic [15:0] a;
    logic        d;
    logic        w;
    logic        b;
    logic [3:0]  e;
  } row_t;
  row_t rows [6] = '{
    '{16'h0010, 1'b1, 1'b1, 1'b0, 4'b0100},  // Window write.
    '{16'h7FFF, 1'b1, 1'b0, 1'b0, 4'b0110},  // Last window byte.
    '{16'h8000, 1'b1, 1'b0, 1'b0, 4'b1111},  // First expanded byte.
    '{16'h0020, 1'b1, 1'b1, 1'b1, 4'b1000},  // Bank 2 write.
    '{16'h1000, 1'b1, 1'b1, 1'b0, 4'b0110},  // Protected block write.
    '{16'h0010, 1'b0, 1'b0, 1'b0, 4'b0110}}; // Program read back.
  logic clk_sys = 1'b0, reset_n = 1'b0, acc_valid = 1'b0, acc_is_data = 1'b0;
  logic acc_write = 1'b0, acc_bank2 = 1'b0, pfw_enable = 1'b0;
  logic warning_threshold = 1'b0, reset_threshold = 1'b0;
  logic battery_level = 1'b0;
  logic [15:0] acc_addr = 16'h0000;
  logic [7:0]  acc_wdata = 8'h5A, program_block_mask = 8'h02;
  logic [7:0]  acc_rdata_q, bytewide_data_out_q, bytewide_data_in;
  logic        p_n, b_n, ws_n, oe, req, irq, core_reset_q, on_bat;
  logic [14:0] bytewide_address_q;
  logic [15:0] pfw_vector_q;
  int          n_errors = 0, n_compared = 0, cycles = 0, hits;
  // The design under test.
  bytewide_decode_power_fail dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .acc_valid(acc_valid), .acc_is_data(acc_is_data),
    .acc_write(acc_write), .acc_bank2(acc_bank2), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_rdata_q(acc_rdata_q),
    .pfw_enable(pfw_enable), .program_block_mask(program_block_mask),
    .warning_threshold(warning_threshold),
    .reset_threshold(reset_threshold), .battery_level(battery_level),
    .primary_sram_select_n_q(p_n), .data_bank2_select_n_q(b_n),
    .write_strobe_n_q(ws_n), .bytewide_address_q(bytewide_address_q),
    .bytewide_data_out_q(bytewide_data_out_q), .bytewide_data_oe_q(oe),
    .bytewide_data_in(bytewide_data_in), .expanded_req_q(req),
    .pfw_irq_q(irq), .pfw_vector_q(pfw_vector_q),
    .core_reset_q(core_reset_q), .supply_on_battery_q(on_bat));
  // The RAM pair on the far side of the byte-wide bus.
  sram_pair_model ram (.clk_sys(clk_sys), .primary_sram_select_n_q(p_n),
    .data_bank2_select_n_q(b_n), .write_strobe_n_q(ws_n),
    .bytewide_address_q(bytewide_address_q),
    .bytewide_data_out_q(bytewide_data_out_q),
    .bytewide_data_in(bytewide_data_in));
  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // 125 MHz clock.
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // A hang is cut short well past the 46 cycles the tests need.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      finish_test();
    end
  end
  // Main sequence: reset, decode table, then the supply events in order.
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK("reset outputs", 4'b1111, {p_n, b_n, ws_n, core_reset_q})
    reset_n = 1'b1;
    @(posedge clk_sys);
    #1;
    acc_valid = 1'b1;
    foreach (rows[i]) begin
      {acc_addr, acc_is_data, acc_write, acc_bank2} = rows[i][22:4];
      @(posedge clk_sys);
      #1;
      `CHK("decode", rows[i].e, {p_n, b_n, ws_n, req})
      if (!rows[i].e[3] || !rows[i].e[2])
        `CHK("address", {~rows[i].a[14:13], rows[i].a[12:0]}, bytewide_address_q)
    end
    acc_valid = 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("read data", 8'h5A, acc_rdata_q)
    $display("test decode done");
    // Warning: exactly one interrupt pulse, processing goes on.
    pfw_enable = 1'b1;
    warning_threshold = 1'b1;
    hits = 0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      hits += (irq === 1'b1);
    end
    `CHK("irq pulses", 1, hits)
    `CHK("vector", 16'h002B, pfw_vector_q)
    `CHK("core reset", 1'b0, core_reset_q)
    $display("test warning done");
    // Reset threshold with a write pending: the bus must be quiet once in reset.
    reset_threshold = 1'b1;
    {acc_valid, acc_addr, acc_is_data, acc_write} = {1'b1, 16'h0010, 2'b11};
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("core reset", 1'b1, core_reset_q)
    `CHK("held bus", 3'b111, {p_n, b_n, ws_n})
    `CHK("on battery", 1'b0, on_bat)
    battery_level = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("on battery", 1'b1, on_bat)
    {battery_level, reset_threshold, warning_threshold, acc_valid} = 4'h0;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("recovered", 2'b00, {core_reset_q, on_bat})
    $display("test supply done");
    finish_test();
  end
endmodule // test_bytewide_decode_power_fail
`default_nettype wire
